// ===== hdl/ivpu_pkg.sv
// Constants, classes and level helpers for the interrupt priority and vector unit.
package ivpu_pkg;

   // ==========================================================================
   // Sizes
   localparam int          NVEC     = 64;
   localparam int          VW       = 6;
   localparam int          XW       = 19;
   localparam int          RKW      = 3;
   localparam int          AXW      = 8;
   localparam int          FPR      = 16;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0]  OFF_CTRL  = 8'h00;
   localparam logic [7:0]  OFF_BASE  = 8'h04;
   localparam logic [7:0]  OFF_STAT  = 8'h08;
   localparam logic [7:0]  OFF_MASK  = 8'h0C;
   localparam logic [7:0]  OFF_WIN   = 8'h10;
   localparam logic [7:0]  OFF_PRIO0 = 8'h20;

   // ==========================================================================
   // Field positions and values after reset
   localparam int          ST_ACK    = 0;
   localparam int          ST_RSVD   = 1;
   localparam int          STW       = 2;
   localparam int          WIN_NUM   = 8;
   localparam int          WIN_RANK  = 16;
   localparam logic        CTRL_RST  = 1'b1;
   localparam logic [18:0] BASE_RST  = 19'h0_0000;
   localparam logic [1:0]  STAT_RST  = 2'h0;
   localparam logic [1:0]  MASK_RST  = 2'h0;
   localparam logic [1:0]  PRIO_RST  = 2'h0;
   localparam logic [18:0] COP_OFS   = 19'h0_0002;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;

   // ==========================================================================
   // Ranks: 0 means never ranked, level -1 is rank 1, level L is rank L plus 2
   localparam logic [2:0]  RANK_NONE = 3'h0;
   localparam logic [2:0]  RANK_M1   = 3'h1;
   localparam logic [2:0]  RANK_OFS  = 3'h2;

   typedef enum logic [2:0] {
      IVPU_CLS_NONE   = 3'b000,
      IVPU_CLS_FIX3   = 3'b001,
      IVPU_CLS_PROG13 = 3'b010,
      IVPU_CLS_FIX2   = 3'b011,
      IVPU_CLS_FIX1   = 3'b100,
      IVPU_CLS_FIX0   = 3'b101,
      IVPU_CLS_PROG02 = 3'b110,
      IVPU_CLS_FIXM1  = 3'b111
   } ivpu_cls_e;

   function automatic ivpu_cls_e vec_class(input logic [5:0] v);
      ivpu_cls_e c;
      c = IVPU_CLS_PROG02;
      if (v < 6'h02) begin
         c = IVPU_CLS_NONE;
      end else if (v <= 6'h05) begin
         c = IVPU_CLS_FIX3;
      end else if (v <= 6'h0A || v == 6'h0F || v == 6'h10) begin
         c = IVPU_CLS_PROG13;
      end else if (v == 6'h0B) begin
         c = IVPU_CLS_FIX2;
      end else if (v == 6'h0C) begin
         c = IVPU_CLS_FIX1;
      end else if (v == 6'h0D) begin
         c = IVPU_CLS_FIX0;
      end else if (v == 6'h0E || (v >= 6'h14 && v <= 6'h17) || v == 6'h1E || v == 6'h1F
                   || (v >= 6'h24 && v <= 6'h27) || (v >= 6'h31 && v <= 6'h34)) begin
         c = IVPU_CLS_NONE;
      end else if (v == 6'h3F) begin
         c = IVPU_CLS_FIXM1;
      end
      return c;
   endfunction

   // Folds a stored field into the level range that the source allows.
   function automatic logic [1:0] clamp_lvl(input ivpu_cls_e c, input logic [1:0] f);
      logic [1:0] l;
      l = 2'h0;
      case (c)
         IVPU_CLS_FIX3:   l = 2'h3;
         IVPU_CLS_PROG13: l = (f == 2'h0) ? 2'h1 : f;
         IVPU_CLS_FIX2:   l = 2'h2;
         IVPU_CLS_FIX1:   l = 2'h1;
         IVPU_CLS_PROG02: l = (f == 2'h3) ? 2'h2 : f;
         default:         l = 2'h0;
      endcase
      return l;
   endfunction

   function automatic logic [2:0] rank_of(input ivpu_cls_e c, input logic [1:0] f);
      logic [2:0] r;
      if (c == IVPU_CLS_NONE) begin
         r = RANK_NONE;
      end else if (c == IVPU_CLS_FIXM1) begin
         r = RANK_M1;
      end else begin
         r = {1'b0, clamp_lvl(c, f)} + RANK_OFS;
      end
      return r;
   endfunction

endpackage

// ===== hdl/ivpu_rank_if.sv
// Carrier between the unit's register logic and its priority resolver.
`timescale 1ns/1ps
interface ivpu_rank_if;
   logic [63:0] pend;
   logic [2:0]  rank [64];
   logic        win_valid;
   logic [5:0]  win_num;
   logic [2:0]  win_rank;

   modport ctl (output pend, output rank, input win_valid, input win_num, input win_rank);
   modport res (input pend, input rank, output win_valid, output win_num, output win_rank);
endinterface

// ===== hdl/ivpu_resolver.sv
// Priority resolver: picks the highest rank, and the lowest vector among equals.
`timescale 1ns/1ps
module ivpu_resolver (
   ivpu_rank_if.res rif
);

   always_comb begin
      logic [2:0] best;
      logic [5:0] num;
      logic       any;
      best = ivpu_pkg::RANK_NONE;
      num  = 6'h00;
      any  = 1'b0;
      // Scanning downward with >= lets the smaller vector take a tie.
      // higher rank wins
      for (int i = ivpu_pkg::NVEC - 1; i >= 0; i--) begin
         if (rif.pend[i] && rif.rank[i] >= best) begin
            best = rif.rank[i];
            num  = 6'(i);
            any  = 1'b1;
         end
      end
      rif.win_valid = any;
      rif.win_num   = num;
      rif.win_rank  = best;
   end

endmodule

// ===== hdl/ivpu_top.sv
// Interrupt priority and vector unit with an AXI4-Lite register slave.
`timescale 1ns/1ps
module ivpu_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [63:0] irq_req,
   input  wire logic        core_ack,
   output logic             vec_valid,
   output logic [5:0]       vec_num,
   output logic [2:0]       vec_rank,
   output logic [18:0]      vec_addr,
   output logic [18:0]      reset_addr,
   output logic [18:0]      cop_addr,
   output logic             irq
);

   // ==========================================================================
   // State
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic        aw_hold_r, w_hold_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic        enable_r;
   logic [18:0] base_r;
   logic [1:0]  stat_r, mask_r;
   logic [1:0]  prio_r   [64];
   logic [1:0]  prio_nxt [64];
   logic        vec_valid_r;
   logic [5:0]  vec_num_r;
   logic [2:0]  vec_rank_r;
   logic [18:0] vec_addr_r, reset_addr_r, cop_addr_r;
   logic        irq_r;

   ivpu_rank_if rif ();

   ivpu_resolver u_resolver (
      .rif (rif)
   );

   // ==========================================================================
   // Classes and ranks
   logic [63:0] rsvd_mask;
   logic [31:0] prio_word [4];

   always_comb begin
      for (int i = 0; i < ivpu_pkg::NVEC; i++) begin
         rsvd_mask[i] = (ivpu_pkg::vec_class(6'(i)) == ivpu_pkg::IVPU_CLS_NONE);
         rif.rank[i]  = ivpu_pkg::rank_of(ivpu_pkg::vec_class(6'(i)), prio_r[i]);
      end
   end

   assign rif.pend = irq_req & ~rsvd_mask & {64{enable_r}};

   // ==========================================================================
   // Bus decode
   logic        wr_go, rd_go, b_done, r_done;
   logic [7:0]  wa, ra;
   logic        w_ctrl, w_base, w_stat, w_mask, w_prio, w_map;
   logic [1:0]  w_pidx;

   assign wr_go  = aw_hold_r & w_hold_r & ~bvalid_r;
   assign rd_go  = s_axi_arvalid & arready_r;
   assign b_done = bvalid_r & s_axi_bready;
   assign r_done = rvalid_r & s_axi_rready;
   assign wa     = {awaddr_r[7:2], 2'b00};
   assign ra     = {s_axi_araddr[7:2], 2'b00};
   assign w_ctrl = (wa == ivpu_pkg::OFF_CTRL);
   assign w_base = (wa == ivpu_pkg::OFF_BASE);
   assign w_stat = (wa == ivpu_pkg::OFF_STAT);
   assign w_mask = (wa == ivpu_pkg::OFF_MASK);
   assign w_prio = (wa[7:4] == ivpu_pkg::OFF_PRIO0[7:4]);
   assign w_pidx = wa[3:2];
   assign w_map  = w_ctrl | w_base | w_stat | w_mask | w_prio | (wa == ivpu_pkg::OFF_WIN);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] m;
      for (int b = 0; b < 4; b++) begin
         m[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
      return m;
   endfunction

   logic [31:0] base_m;
   assign base_m = merge({13'h0000, base_r}, wdata_r, wstrb_r);

   always_comb begin
      for (int i = 0; i < ivpu_pkg::NVEC; i++) begin
         prio_nxt[i] = prio_r[i];
         if (wr_go && w_prio && w_pidx == 2'(i / ivpu_pkg::FPR)
             && wstrb_r[(i % ivpu_pkg::FPR) / 4]) begin
            prio_nxt[i] = ivpu_pkg::clamp_lvl(ivpu_pkg::vec_class(6'(i)),
                                              wdata_r[2 * (i % ivpu_pkg::FPR) +: 2]);
         end
      end
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < ivpu_pkg::FPR; j++) begin
            prio_word[k][2*j +: 2] = ivpu_pkg::clamp_lvl(
               ivpu_pkg::vec_class(6'(k * ivpu_pkg::FPR + j)),
               prio_r[k * ivpu_pkg::FPR + j]);
         end
      end
   end

   // ==========================================================================
   // Status, mask and interrupt
   logic [1:0] ev, stat_nxt;
   assign ev[ivpu_pkg::ST_ACK]  = core_ack & vec_valid_r;
   assign ev[ivpu_pkg::ST_RSVD] = |(irq_req & rsvd_mask);
   // A clear and a new event in one cycle leave the bit set.
   assign stat_nxt = (stat_r & ~((wr_go & w_stat & wstrb_r[0]) ? wdata_r[1:0] : 2'b00)) | ev;

   // ==========================================================================
   // Read data
   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (ra == ivpu_pkg::OFF_CTRL) begin
         rd_word[0] = enable_r;
      end else if (ra == ivpu_pkg::OFF_BASE) begin
         rd_word[18:0] = base_r;
      end else if (ra == ivpu_pkg::OFF_STAT) begin
         rd_word[1:0] = stat_r;
      end else if (ra == ivpu_pkg::OFF_MASK) begin
         rd_word[1:0] = mask_r;
      end else if (ra == ivpu_pkg::OFF_WIN) begin
         rd_word[0] = vec_valid_r;
         rd_word[ivpu_pkg::WIN_NUM +: 6]  = vec_num_r;
         rd_word[ivpu_pkg::WIN_RANK +: 3] = vec_rank_r;
      end else if (ra[7:4] == ivpu_pkg::OFF_PRIO0[7:4]) begin
         rd_word = prio_word[ra[3:2]];
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ==========================================================================
   // AXI4-Lite handshakes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= ivpu_pkg::RESP_OK;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= w_map ? ivpu_pkg::RESP_OK : ivpu_pkg::RESP_ERR;
         end
         if (b_done) begin
            bvalid_r  <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= ivpu_pkg::RESP_OK;
      end else if (rd_go) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_word;
         rresp_r   <= rd_hit ? ivpu_pkg::RESP_OK : ivpu_pkg::RESP_ERR;
      end else if (r_done) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // ==========================================================================
   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= ivpu_pkg::CTRL_RST;
         base_r   <= ivpu_pkg::BASE_RST;
         stat_r   <= ivpu_pkg::STAT_RST;
         mask_r   <= ivpu_pkg::MASK_RST;
         irq_r    <= 1'b0;
      end else begin
         if (wr_go && w_ctrl && wstrb_r[0]) begin
            enable_r <= wdata_r[0];
         end
         if (wr_go && w_base) begin
            base_r <= base_m[18:0];
         end
         if (wr_go && w_mask && wstrb_r[0]) begin
            mask_r <= wdata_r[1:0];
         end
         stat_r <= stat_nxt;
         irq_r  <= |(stat_nxt & mask_r);
      end
   end

   always_ff @(posedge aclk) begin
      for (int i = 0; i < ivpu_pkg::NVEC; i++) begin
         if (!aresetn) begin
            prio_r[i] <= ivpu_pkg::PRIO_RST;
         end else begin
            prio_r[i] <= prio_nxt[i];
         end
      end
   end

   // ==========================================================================
   // Vector outputs
   // The entry address wraps inside 19 bits; the table cannot reach farther.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vec_valid_r  <= 1'b0;
         vec_num_r    <= 6'h00;
         vec_rank_r   <= ivpu_pkg::RANK_NONE;
         vec_addr_r   <= ivpu_pkg::BASE_RST;
         reset_addr_r <= ivpu_pkg::BASE_RST;
         cop_addr_r   <= ivpu_pkg::BASE_RST + ivpu_pkg::COP_OFS;
      end else begin
         vec_valid_r  <= rif.win_valid;
         vec_num_r    <= rif.win_num;
         vec_rank_r   <= rif.win_rank;
         vec_addr_r   <= base_r + {12'h000, rif.win_num, 1'b0};
         reset_addr_r <= base_r;
         cop_addr_r   <= base_r + ivpu_pkg::COP_OFS;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign vec_valid     = vec_valid_r;
   assign vec_num       = vec_num_r;
   assign vec_rank      = vec_rank_r;
   assign vec_addr      = vec_addr_r;
   assign reset_addr    = reset_addr_r;
   assign cop_addr      = cop_addr_r;
   assign irq           = irq_r;

   // ==========================================================================
   // Checks
   logic beat_lvl, beat_tie;
   always_comb begin
      beat_lvl = 1'b0;
      beat_tie = 1'b0;
      for (int i = 0; i < ivpu_pkg::NVEC; i++) begin
         if (rif.pend[i] && rif.rank[i] > rif.win_rank) begin
            beat_lvl = 1'b1;
         end
         if (rif.pend[i] && rif.rank[i] == rif.win_rank && 6'(i) < rif.win_num) begin
            beat_tie = 1'b1;
         end
      end
   end

   a_level_order: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.win_valid |-> !beat_lvl && rif.pend[rif.win_num]) else $error("lower level won");
   a_tie_lowest: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.win_valid |-> !beat_tie) else $error("larger vector won a tie");
   a_entry_addr: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 vec_valid |-> vec_addr == 19'($past(base_r) + 19'(2 * $past(rif.win_num))))
      else $error("entry address wrong");
   a_base_move: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && w_base && wstrb_r == 4'hF |-> ##2 reset_addr == $past(wdata_r[18:0], 2))
      else $error("base write not used");
   a_reset_slots: assert property (@(posedge aclk) disable iff (!aresetn)
      cop_addr == 19'(reset_addr + 19'h0_0002) && !rif.pend[0] && !rif.pend[1])
      else $error("reset slots wrong");
   a_core_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.rank[2] == 3'h5 && rif.rank[5] == 3'h5) else $error("core level not three");
   a_debug_range: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.rank[6] >= 3'h3 && rif.rank[10] >= 3'h3) else $error("debug level out of range");
   a_sense_range: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.rank[15] >= 3'h3 && rif.rank[16] >= 3'h3) else $error("sense level out of range");
   a_periph_range: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.rank[17] inside {[3'h2:3'h4]} && rif.rank[62] inside {[3'h2:3'h4]})
      else $error("peripheral level out of range");
   a_lowest_soft: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.rank[63] == 3'h1) else $error("lowest soft interrupt not lowest");
   a_prog_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && w_prio && w_pidx == 2'h1 && wstrb_r[0] && wdata_r[1:0] == 2'h3
      |=> rif.rank[16] == 3'h5) else $error("level write lost");
   a_reserved_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
      (rif.pend & rsvd_mask) == 64'h0000_0000_0000_0000 && rif.rank[11] == 3'h4
      && rif.rank[13] == 3'h2) else $error("reserved slot raised");

endmodule

// ===== testbench/ivpu_core_model.sv
// Behavioural processor core that takes the vectors the unit offers.
`timescale 1ns/1ps
module ivpu_core_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic take,
   input  wire logic vec_valid,
   output logic      core_ack
);
   // A slow core is modelled by holding take low, so a request may wait unanswered.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_ack <= 1'b0;
      end else begin
         core_ack <= take && vec_valid && !core_ack;
      end
   end
endmodule

// ===== testbench/ivpu_top_test.sv
// Self-checking bench for the interrupt priority and vector unit.
`timescale 1ns/1ps
module ivpu_top_test;
   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic        awvalid = 1'b0;
   logic        awready;
   logic [31:0] wdata   = 32'h0000_0000;
   logic        wvalid  = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready  = 1'b0;
   logic [7:0]  araddr  = 8'h00;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready  = 1'b0;
   logic [63:0] irq_req = 64'h0000_0000_0000_0000;
   logic        take    = 1'b0;
   logic        core_ack;
   logic        vec_valid;
   logic [5:0]  vec_num;
   logic [2:0]  vec_rank;
   logic [18:0] vec_addr;
   logic [18:0] reset_addr;
   logic [18:0] cop_addr;
   logic        irq;
   logic [18:0] bs      = 19'h0_0000;
   logic [1:0]  rs;
   logic [31:0] rd;
   int          n_fail     = 0;
   int          n_compared = 0;

   ivpu_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq_req(irq_req), .core_ack(core_ack),
      .vec_valid(vec_valid), .vec_num(vec_num), .vec_rank(vec_rank), .vec_addr(vec_addr),
      .reset_addr(reset_addr), .cop_addr(cop_addr), .irq(irq));

   ivpu_core_model core (.aclk(aclk), .aresetn(aresetn), .take(take),
      .vec_valid(vec_valid), .core_ack(core_ack));

   always #2.5 aclk = ~aclk;

   // ==========================================================================
   // Access and compare tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      rs = bresp;
      bready <= 1'b0;
      // Outputs registered from the new value change at this very edge; let them settle.
      #1;
   endtask

   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   function automatic logic [63:0] b(input int i);
      return 64'h0000_0000_0000_0001 << i;
   endfunction

   // Writes one level field; the other fields of that word fall to the lowest level their source allows.
   task automatic lv(input logic [5:0] v, input logic [1:0] l);
      wr(8'h20 + {2'b00, v[5:4], 2'b00}, {30'h0000_0000, l} << {v[3:0], 1'b0});
   endtask

   // One cycle after the request the winner and its entry address are shown.
   task automatic tv(input logic [63:0] p, input logic [5:0] n, input logic [2:0] k);
      @(posedge aclk);
      irq_req <= p;
      @(posedge aclk);
      #1;
      chk({31'h0, vec_valid}, 32'h1);
      chk({26'h0, vec_num}, {26'h0, n});
      chk({29'h0, vec_rank}, {29'h0, k});
      chk({13'h0, vec_addr}, {13'h0, bs + {12'h000, n, 1'b0}});
   endtask

   task automatic none(input logic [63:0] p);
      @(posedge aclk);
      irq_req <= p;
      @(posedge aclk);
      #1;
      chk({31'h0, vec_valid}, 32'h0);
   endtask

   task automatic finish_test;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_fail++;
      finish_test();
   end

   // ==========================================================================
   // Tests
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(8'h00);
      chk(rd, 32'h0000_0001);
      rdr(8'h04);
      chk(rd, 32'h0000_0000);
      rdr(8'h0C);
      chk(rd, 32'h0000_0000);
      chk({13'h0, cop_addr}, 32'h0000_0002);
      $display("test reset done");
      bs = 19'h0_0100;
      wr(8'h04, 32'h0000_0100);
      chk({13'h0, reset_addr}, 32'h0000_0100);
      chk({13'h0, cop_addr}, 32'h0000_0102);
      tv(b(40), 6'd40, 3'd2);
      lv(6'd40, 2'h2);
      tv(b(40) | b(17), 6'd40, 3'd4);
      tv(b(17) | b(18), 6'd17, 3'd2);
      lv(6'd6, 2'h3);
      tv(b(5) | b(6) | b(40), 6'd5, 3'd5);
      tv(b(6) | b(40), 6'd6, 3'd5);
      tv(b(16) | b(40), 6'd40, 3'd4);
      lv(6'd16, 2'h3);
      tv(b(16) | b(40), 6'd16, 3'd5);
      tv(b(11) | b(12) | b(13) | b(63), 6'd11, 3'd4);
      tv(b(12) | b(13) | b(63), 6'd12, 3'd3);
      tv(b(13) | b(63), 6'd13, 3'd2);
      tv(b(63), 6'd63, 3'd1);
      $display("test ranking done");
      lv(6'd40, 2'h3);
      rdr(8'h28);
      chk(rd, 32'h0002_0000);
      lv(6'd6, 2'h0);
      rdr(8'h20);
      chk(rd, 32'h4195_5FF0);
      $display("test levels done");
      wr(8'h08, 32'h0000_0003);
      none(b(0) | b(1) | b(14) | b(20) | b(30) | b(36) | b(49));
      rdr(8'h08);
      chk(rd, 32'h0000_0002);
      none(64'h0000_0000_0000_0000);
      wr(8'h08, 32'h0000_0002);
      rdr(8'h08);
      chk(rd, 32'h0000_0000);
      $display("test reserved done");
      bs = 19'h7_FFF0;
      wr(8'h04, 32'h0007_FFF0);
      tv(b(63), 6'd63, 3'd1);
      chk({13'h0, cop_addr}, 32'h0007_FFF2);
      wr(8'h00, 32'h0000_0000);
      none(b(40));
      wr(8'h00, 32'h0000_0001);
      $display("test base and enable done");
      wr(8'h0C, 32'h0000_0001);
      tv(b(40), 6'd40, 3'd4);
      rdr(8'h10);
      chk(rd, 32'h0004_2801);
      chk({31'h0, irq}, 32'h0);
      take <= 1'b1;
      repeat (4) @(posedge aclk);
      take <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      rdr(8'h08);
      chk(rd, 32'h0000_0001);
      wr(8'h08, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      $display("test interrupt done");
      wr(8'h40, 32'h0000_0001);
      chk({30'h0, rs}, 32'h0000_0002);
      rdr(8'h40);
      chk({30'h0, rs}, 32'h0000_0002);
      chk(rd, 32'h0000_0000);
      $display("test unmapped done");
      finish_test();
   end
endmodule
